// ===== rtl/sirs_cfg.svh
// sirs_cfg.svh: offsets, field positions, reset values and codes of the
// sensor interrupt and response status block.
// assumes: included by bare name, byte addresses are four times the index.
`ifndef SIRS_CFG_SVH
`define SIRS_CFG_SVH

// register indices, byte address is index times four
`define SIRS_IDX_INT_CFG      6'h03
`define SIRS_IDX_IRQ_EN       6'h04
`define SIRS_IDX_MODE_A       6'h05
`define SIRS_IDX_MODE_B       6'h06
`define SIRS_IDX_LED_PAIR     6'h0F
`define SIRS_IDX_LED_THIRD    6'h10
`define SIRS_IDX_COMMAND      6'h18
`define SIRS_IDX_RESPONSE     6'h20
`define SIRS_IDX_IRQ_FLAGS    6'h21
`define SIRS_IDX_PIN_STAT     6'h31

// field positions
`define SIRS_BIT_PIN_OE       0
`define SIRS_BIT_PROX_ONE     2
`define SIRS_BIT_PROX_TWO     3
`define SIRS_BIT_PROX_THREE   4
`define SIRS_AMB_LSB          0
`define SIRS_AMB_MSB          1
`define SIRS_FLAG_MASK        8'h1F

// reset values
`define SIRS_RST_BYTE         8'h00
`define SIRS_RST_NIBBLE       4'h0

// ambient enable field values
`define SIRS_AMB_OFF          2'h0
`define SIRS_AMB_EVERY        2'h1

// command and response codes
`define SIRS_CMD_NOP          8'h00
`define SIRS_RESP_INVALID     8'h80
`define SIRS_RESP_OVF_P1      8'h88
`define SIRS_RESP_OVF_P2      8'h89
`define SIRS_RESP_OVF_P3      8'h8A
`define SIRS_RESP_OVF_VIS     8'h8C
`define SIRS_RESP_OVF_IR      8'h8D
`define SIRS_RESP_OVF_AUX     8'h8E

// synchroniser depth
`define SIRS_SYNC_STAGES      2

`endif

// ===== rtl/sirs_pkg.sv
// sirs_pkg.sv: types shared by the interrupt and response status files.
// assumes: numbers live in sirs_cfg.svh, this holds types only.
package sirs_pkg;

    // one register byte
    typedef logic [7:0] sirs_byte_t;

    // bus slave answer state
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ANSWER
    } sirs_bus_e;

endpackage

// ===== rtl/sirs_sync.sv
// sirs_sync.sv: two flip-flop synchroniser for pin inputs.
// assumes: first stage is read only by the second stage.
`timescale 1ns/1ps
`include "sirs_cfg.svh"

module sirs_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);

    logic [`SIRS_SYNC_STAGES-1:0] stage_ff; // shift chain

    //////////////////////////////////////////////////////////////////////
    // chain of stages, built by a generate loop
    genvar g;
    generate
        for (g = 0; g < `SIRS_SYNC_STAGES; g = g + 1) begin : g_stage
            if (g == 0) begin : g_first
                always_ff @(posedge sys_clk) begin
                    if (!rst_n) begin
                        stage_ff[g] <= 1'b1;
                    end else begin
                        stage_ff[g] <= async_in;
                    end
                end
            end else begin : g_next
                always_ff @(posedge sys_clk) begin
                    if (!rst_n) begin
                        stage_ff[g] <= 1'b1;
                    end else begin
                        stage_ff[g] <= stage_ff[g-1];
                    end
                end
            end
        end
    endgenerate

    // last stage is the clean level
    assign sync_out = stage_ff[`SIRS_SYNC_STAGES-1];

endmodule

// ===== rtl/sirs_resp.sv
// sirs_resp.sv: response code register with rolling completion counter.
// assumes: event inputs are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
`include "sirs_cfg.svh"

module sirs_resp (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             nop_clear,
    input  wire logic             cmd_done,
    input  wire logic             invalid_set,
    input  wire logic [5:0]       overflow,
    output sirs_pkg::sirs_byte_t  response
);

    sirs_pkg::sirs_byte_t resp_ff;      // held response code
    sirs_pkg::sirs_byte_t nxt_resp;     // next response code
    sirs_pkg::sirs_byte_t ovf_code;     // code of first overflow
    logic                 held_invalid; // invalid code stays until nop
    logic                 no_error;     // upper nibble clear
    logic [3:0]           count_inc;    // counter plus one, wraps

    //////////////////////////////////////////////////////////////////////
    // overflow code, lowest channel first
    assign ovf_code = overflow[0] ? `SIRS_RESP_OVF_P1 :
                      overflow[1] ? `SIRS_RESP_OVF_P2 :
                      overflow[2] ? `SIRS_RESP_OVF_P3 :
                      overflow[3] ? `SIRS_RESP_OVF_VIS :
                      overflow[4] ? `SIRS_RESP_OVF_IR :
                                    `SIRS_RESP_OVF_AUX;

    assign held_invalid = (resp_ff == `SIRS_RESP_INVALID);
    assign no_error     = (resp_ff[7:4] == `SIRS_RST_NIBBLE);
    assign count_inc    = resp_ff[3:0] + 4'h1;

    // priority: nop, invalid, held invalid, overflow, completion
    assign nxt_resp =
        nop_clear    ? `SIRS_RST_BYTE :
        invalid_set  ? `SIRS_RESP_INVALID :
        held_invalid ? resp_ff :
        (|overflow)  ? ovf_code :
        (cmd_done && no_error) ? {`SIRS_RST_NIBBLE, count_inc} :
                       resp_ff;

    //////////////////////////////////////////////////////////////////////
    // response register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            resp_ff <= `SIRS_RST_BYTE;
        end else begin
            resp_ff <= nxt_resp;
        end
    end

    // upper nibble non-zero flags an error to software
    assign response = resp_ff;

endmodule

// ===== rtl/sirs_top.sv
// sirs_top.sv: interrupt flags, mask, pin drive, response code, led
// current fields and the avalon-mm register slave of the sensor.
// assumes: sequencer events arrive as one-cycle pulses on sys_clk,
// the interrupt pin is open drain with an external pull-up.
//
// How it works
// - good completion bumps low nibble counter
// - nop command zeroes the response code
// - invalid setting code held until nop
// - proximity overflows give codes 88, 89, 8A
// - ambient and aux overflows give 8C-8E
// - mask bit 2 arms proximity one flag
// - mask bit 3 arms proximity two flag
// - mask bit 4 arms proximity three flag
// - ambient field 01 flags visible or uv
// - pin driven only with output enable set
// - mask and flags anded drive pin
// - writing one clears a flag bit
// - mask alone decides flag setting, modes only go out to the sequencer
// - led currents in four bit fields
// - non-zero upper nibble means error
// - pin pulled low on enabled flag
`timescale 1ns/1ps
`include "sirs_cfg.svh"

module sirs_top (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // sequencer events
    input  wire logic        prox_one_sample,
    input  wire logic        prox_two_sample,
    input  wire logic        prox_three_sample,
    input  wire logic        visible_sample,
    input  wire logic        uv_sample,
    input  wire logic        cmd_done,
    input  wire logic        invalid_setting,
    input  wire logic [5:0]  overflow,
    // sequencer controls
    output logic      [7:0]  command_value,
    output logic             command_strobe,
    output logic      [7:0]  irq_mode_reg_a,
    output logic      [7:0]  irq_mode_reg_b,
    output logic      [3:0]  led_one_current,
    output logic      [3:0]  led_two_current,
    output logic      [3:0]  led_three_current,
    // open drain interrupt pin
    input  wire logic        irq_pin_in,
    output logic             irq_pin_out,
    output logic             irq_pin_oe
);

    //////////////////////////////////////////////////////////////////////
    // declarations
    sirs_pkg::sirs_bus_e  bus_state_ff;   // slave answer state
    sirs_pkg::sirs_bus_e  nxt_bus_state;  // next answer state
    logic [31:0]          rdata_ff;       // captured read word
    logic [31:0]          nxt_rdata;      // read word being built
    sirs_pkg::sirs_byte_t int_cfg_ff;     // pin output enable
    sirs_pkg::sirs_byte_t irq_en_ff;      // interrupt enable mask
    sirs_pkg::sirs_byte_t mode_a_ff;      // interrupt mode a
    sirs_pkg::sirs_byte_t mode_b_ff;      // interrupt mode b
    sirs_pkg::sirs_byte_t led_pair_ff;    // led one and two current
    sirs_pkg::sirs_byte_t led_third_ff;   // led three current
    sirs_pkg::sirs_byte_t cmd_ff;         // last command written
    logic                 cmd_stb_ff;     // one-cycle command pulse
    sirs_pkg::sirs_byte_t flags_ff;       // interrupt flags
    sirs_pkg::sirs_byte_t nxt_flags;      // next flags
    sirs_pkg::sirs_byte_t flag_set;       // flags raised this cycle
    sirs_pkg::sirs_byte_t flag_clr;       // flags cleared by software
    sirs_pkg::sirs_byte_t response;       // response code
    logic                 irq_oe_ff;      // registered pin drive
    logic                 pin_level;      // synchronised pin level
    logic                 answer;         // access completes now
    logic                 wr_take;        // write takes effect
    logic                 wr_lane;        // write with low byte lane
    logic                 nop_clear;      // nop command written
    logic                 irq_active;     // any enabled flag set
    logic                 amb_armed;      // ambient field selects 01
    logic [5:0]           idx;            // register index

    //////////////////////////////////////////////////////////////////////
    // address decode, used by both read and write paths
    function automatic logic reg_hit(input logic [5:0] a,
                                     input logic [5:0] r);
        reg_hit = (a == r);
    endfunction

    assign idx     = avs_address[7:2];
    assign answer  = (bus_state_ff == sirs_pkg::BUS_ANSWER);
    assign wr_take = answer && avs_write;
    assign wr_lane = wr_take && avs_byteenable[0];

    //////////////////////////////////////////////////////////////////////
    // slave handshake: one wait cycle, answer on the second
    // the master holds its request through the wait cycle, so the
    // write lands and read data stand at the edge waitrequest is low
    assign avs_waitrequest = !answer;
    assign nxt_bus_state   = answer ? sirs_pkg::BUS_IDLE :
                             (avs_read || avs_write) ?
                             sirs_pkg::BUS_ANSWER : sirs_pkg::BUS_IDLE;

    // state of the slave
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_state_ff <= sirs_pkg::BUS_IDLE;
        end else begin
            bus_state_ff <= nxt_bus_state;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // read mux, unmapped indices read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (reg_hit(idx, `SIRS_IDX_INT_CFG)) begin
            nxt_rdata[7:0] = int_cfg_ff;
        end else if (reg_hit(idx, `SIRS_IDX_IRQ_EN)) begin
            nxt_rdata[7:0] = irq_en_ff;
        end else if (reg_hit(idx, `SIRS_IDX_MODE_A)) begin
            nxt_rdata[7:0] = mode_a_ff;
        end else if (reg_hit(idx, `SIRS_IDX_MODE_B)) begin
            nxt_rdata[7:0] = mode_b_ff;
        end else if (reg_hit(idx, `SIRS_IDX_LED_PAIR)) begin
            nxt_rdata[7:0] = led_pair_ff;
        end else if (reg_hit(idx, `SIRS_IDX_LED_THIRD)) begin
            nxt_rdata[7:0] = led_third_ff;
        end else if (reg_hit(idx, `SIRS_IDX_COMMAND)) begin
            nxt_rdata[7:0] = cmd_ff;
        end else if (reg_hit(idx, `SIRS_IDX_RESPONSE)) begin
            nxt_rdata[7:0] = response;
        end else if (reg_hit(idx, `SIRS_IDX_IRQ_FLAGS)) begin
            nxt_rdata[7:0] = flags_ff;
        end else if (reg_hit(idx, `SIRS_IDX_PIN_STAT)) begin
            nxt_rdata[0] = pin_level;
            nxt_rdata[1] = irq_active;
        end
    end

    // read word captured on the wait cycle, stands while answering
    // capturing one cycle early keeps readdata a plain flop output
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (!answer && avs_read) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_readdata = rdata_ff;

    //////////////////////////////////////////////////////////////////////
    // writable configuration registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_cfg_ff   <= `SIRS_RST_BYTE;
            irq_en_ff    <= `SIRS_RST_BYTE;
            mode_a_ff    <= `SIRS_RST_BYTE;
            mode_b_ff    <= `SIRS_RST_BYTE;
            led_pair_ff  <= `SIRS_RST_BYTE;
            led_third_ff <= `SIRS_RST_BYTE;
        end else if (wr_lane) begin
            // only bit 0 of the pin config is kept
            if (reg_hit(idx, `SIRS_IDX_INT_CFG)) begin
                int_cfg_ff <= {7'h00, avs_writedata[`SIRS_BIT_PIN_OE]};
            end
            // unused mask bits read zero
            if (reg_hit(idx, `SIRS_IDX_IRQ_EN)) begin
                irq_en_ff <= avs_writedata[7:0] & `SIRS_FLAG_MASK;
            end
            if (reg_hit(idx, `SIRS_IDX_MODE_A)) begin
                mode_a_ff <= avs_writedata[7:0];
            end
            if (reg_hit(idx, `SIRS_IDX_MODE_B)) begin
                mode_b_ff <= avs_writedata[7:0];
            end
            if (reg_hit(idx, `SIRS_IDX_LED_PAIR)) begin
                led_pair_ff <= avs_writedata[7:0];
            end
            if (reg_hit(idx, `SIRS_IDX_LED_THIRD)) begin
                led_third_ff <= {4'h0, avs_writedata[3:0]};
            end
        end
    end

    // led current fields
    assign led_one_current   = led_pair_ff[3:0];
    assign led_two_current   = led_pair_ff[7:4];
    assign led_three_current = led_third_ff[3:0];
    assign irq_mode_reg_a    = mode_a_ff;
    assign irq_mode_reg_b    = mode_b_ff;

    //////////////////////////////////////////////////////////////////////
    // command register and its pulse to the sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_ff     <= `SIRS_RST_BYTE;
            cmd_stb_ff <= 1'b0;
        end else begin
            cmd_stb_ff <= wr_lane && reg_hit(idx, `SIRS_IDX_COMMAND);
            if (wr_lane && reg_hit(idx, `SIRS_IDX_COMMAND)) begin
                cmd_ff <= avs_writedata[7:0];
            end
        end
    end

    assign command_value  = cmd_ff;
    assign command_strobe = cmd_stb_ff;

    // nop write clears the response at once
    assign nop_clear = wr_lane && reg_hit(idx, `SIRS_IDX_COMMAND) &&
                       (avs_writedata[7:0] == `SIRS_CMD_NOP);

    //////////////////////////////////////////////////////////////////////
    // response code
    sirs_resp u_resp (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .nop_clear   (nop_clear),
        .cmd_done    (cmd_done),
        .invalid_set (invalid_setting),
        .overflow    (overflow),
        .response    (response)
    );

    //////////////////////////////////////////////////////////////////////
    // flag raising, gated by the mask
    assign amb_armed = (irq_en_ff[`SIRS_AMB_MSB:`SIRS_AMB_LSB] ==
                        `SIRS_AMB_EVERY);

    always_comb begin
        flag_set = `SIRS_RST_BYTE;
        // proximity one
        flag_set[`SIRS_BIT_PROX_ONE] = prox_one_sample &&
                                       irq_en_ff[`SIRS_BIT_PROX_ONE];
        // proximity two
        flag_set[`SIRS_BIT_PROX_TWO] = prox_two_sample &&
                                       irq_en_ff[`SIRS_BIT_PROX_TWO];
        // proximity three
        flag_set[`SIRS_BIT_PROX_THREE] = prox_three_sample &&
                                         irq_en_ff[`SIRS_BIT_PROX_THREE];
        // ambient on visible or uv sample
        flag_set[`SIRS_AMB_LSB] = amb_armed &&
                                  (visible_sample || uv_sample);
    end

    // write one to clear, zero leaves a flag
    assign flag_clr = (wr_lane && reg_hit(idx, `SIRS_IDX_IRQ_FLAGS)) ?
                      avs_writedata[7:0] : `SIRS_RST_BYTE;

    // a set in the clearing cycle wins
    // so an event racing a software clear is never lost
    assign nxt_flags = ((flags_ff & ~flag_clr) | flag_set) &
                       `SIRS_FLAG_MASK;

    // flag register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags_ff <= `SIRS_RST_BYTE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // pin drive: and of mask and flags, gated by output enable
    assign irq_active = |(flags_ff & irq_en_ff);

    // registered drive, decode settling never glitches the line
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_oe_ff <= 1'b0;
        end else begin
            // drive low while enabled, release otherwise
            irq_oe_ff <= int_cfg_ff[`SIRS_BIT_PIN_OE] &&
                         irq_active;
        end
    end

    // open drain: output low, enable carries the drive
    assign irq_pin_out = 1'b0;
    assign irq_pin_oe  = irq_oe_ff;

    // pin level readback through a synchroniser
    // stages reset high, the released level, so no false low follows reset
    sirs_sync u_pin_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (irq_pin_in),
        .sync_out (pin_level)
    );

endmodule

// ===== tb/sirs_monitor.sv
// sirs_monitor.sv: port-level assertions for the interrupt status block.
// assumes: bound to sirs_top, one clock, synchronous active-low reset.
`timescale 1ns/1ps

module sirs_monitor (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic [7:0]  command_value,
    input wire logic        command_strobe,
    input wire logic [7:0]  irq_mode_reg_a,
    input wire logic [7:0]  irq_mode_reg_b,
    input wire logic [3:0]  led_one_current,
    input wire logic [3:0]  led_two_current,
    input wire logic [3:0]  led_three_current,
    input wire logic        irq_pin_out,
    input wire logic        irq_pin_oe
);
    ////////////////////////////////////////////////////////////////////
    // write taken at this edge, and its register index
    wire       tk = avs_write & ~avs_waitrequest & avs_byteenable[0];
    wire [5:0] ix = avs_address[7:2];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////
    wait_answer_a: assert property ($rose(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("no answer");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    cmd_store_a: assert property (tk && ix == 6'h18
        |=> command_strobe && command_value == $past(avs_writedata[7:0]))
        else $error("command not stored");
    strobe_pulse_a: assert property (command_strobe |=> !command_strobe)
        else $error("strobe too long");
    led_pair_a: assert property (tk && ix == 6'h0F
        |=> {led_two_current, led_one_current}
            == $past(avs_writedata[7:0])) else $error("led pair wrong");
    led_third_a: assert property (tk && ix == 6'h10
        |=> led_three_current == $past(avs_writedata[3:0]))
        else $error("led third wrong");
    mode_first_a: assert property (tk && ix == 6'h05
        |=> irq_mode_reg_a == $past(avs_writedata[7:0]))
        else $error("mode a wrong");
    mode_second_a: assert property (tk && ix == 6'h06
        |=> irq_mode_reg_b == $past(avs_writedata[7:0]))
        else $error("mode b wrong");
    pin_low_a: assert property (irq_pin_oe |-> !irq_pin_out)
        else $error("pin driven high");
    pin_gate_a: assert property (tk && ix == 6'h03
        && !avs_writedata[0] |-> ##2 !irq_pin_oe) else $error("pin driven");
    oe_fall_a: assert property ($fell(irq_pin_oe)
        |-> $past(tk, 2)) else $error("pin released without write");
endmodule

// ===== tb/sirs_line_model.sv
// sirs_line_model.sv: board side of the open-drain interrupt line.
// assumes: external pull-up, device only ever pulls low.
`timescale 1ns/1ps

module sirs_line_model (
    input  wire logic irq_pin_out,
    input  wire logic irq_pin_oe,
    output logic      irq_line
);
    // pull-up wins whenever the device lets go
    assign irq_line = irq_pin_oe ? irq_pin_out : 1'h1;
endmodule

// ===== tb/sirs_top_tb.sv
// sirs_top_tb.sv: self-checking bench for sirs_top.
// assumes: avalon-mm master tasks, line model feeds the pin back.
`timescale 1ns/1ps

module sirs_top_tb;
    logic        sys_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic [7:0]  adr = 8'h00;        // bus request
    logic        rd_r = 1'h0;
    logic        wr_r = 1'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'h0;
    logic [31:0] rdat;
    logic        wreq;
    logic [4:0]  smp = 5'h00;        // sample pulses
    logic        cdone = 1'h0;
    logic        inv = 1'h0;
    logic [5:0]  ovf = 6'h00;
    logic [7:0]  cval, ma, mb;
    logic        cstb, pout, poe, line;
    logic [3:0]  l1, l2, l3;
    logic [7:0]  q;
    int          fail_count = 0;
    int          checks_done = 0;
    logic [7:0]  oc [6] = '{8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D, 8'h8E};

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    sirs_top u_sirs_top (.sys_clk(sys_clk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .prox_one_sample(smp[0]),
        .prox_two_sample(smp[1]), .prox_three_sample(smp[2]),
        .visible_sample(smp[3]), .uv_sample(smp[4]), .cmd_done(cdone),
        .invalid_setting(inv), .overflow(ovf), .command_value(cval),
        .command_strobe(cstb), .irq_mode_reg_a(ma), .irq_mode_reg_b(mb),
        .led_one_current(l1), .led_two_current(l2),
        .led_three_current(l3), .irq_pin_in(line), .irq_pin_out(pout),
        .irq_pin_oe(poe));

    sirs_line_model u_sirs_line_model (.irq_pin_out(pout),
        .irq_pin_oe(poe), .irq_line(line));

    ////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input string nm, input logic [7:0] got,
                         input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one bus transfer, held until waitrequest is sampled low at a rising
    // edge; data taken and request released at that edge, then settle
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, input logic b0);
        @(posedge sys_clk);
        adr <= a;
        wd <= {24'h0, d};
        be <= {3'h0, b0};
        rd_r <= ~w;
        wr_r <= w;
        // values read here are those the design shows at this edge
        do begin
            @(posedge sys_clk);
        end while (wreq !== 1'h0);
        q = rdat[7:0];
        rd_r <= 1'h0;
        wr_r <= 1'h0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'h1, a, d, 1'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'h0, a, 8'h00, 1'h1);
        check("reg", q, e);
    endtask

    // one-cycle sequencer event, then settle
    task automatic ev(input logic [4:0] s, input logic c, input logic i,
                      input logic [5:0] o);
        @(posedge sys_clk);
        smp <= s;
        cdone <= c;
        inv <= i;
        ovf <= o;
        @(posedge sys_clk);
        smp <= 5'h00;
        cdone <= 1'h0;
        inv <= 1'h0;
        ovf <= 6'h00;
        repeat (4) @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(8'h0C, 8'h00);
        rd(8'hC4, 8'h01);
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'h00);
        wr(8'h80, 8'h55);
        rd(8'h80, 8'h00);
        wr(8'h3C, 8'hA5);
        check("led pair", {l2, l1}, 8'hA5);
        xfer(1'h1, 8'h3C, 8'h00, 1'h0);
        check("led be", {l2, l1}, 8'hA5);
        wr(8'h40, 8'hF7);
        check("led third", {4'h0, l3}, 8'h07);
        wr(8'h14, 8'h5A);
        wr(8'h18, 8'hC3);
        check("mode a", ma, 8'h5A);
        check("mode b", mb, 8'hC3);
        $display("test regs done");
    endtask

    task automatic t_resp;
        wr(8'h60, 8'h00);
        rd(8'h80, 8'h00);
        wr(8'h60, 8'h07);
        rd(8'h80, 8'h00);
        repeat (17) ev(5'h00, 1'h1, 1'h0, 6'h00);
        rd(8'h80, 8'h01);
        ev(5'h00, 1'h0, 1'h1, 6'h00);
        rd(8'h80, 8'h80);
        ev(5'h00, 1'h1, 1'h0, 6'h01);
        rd(8'h80, 8'h80);
        for (int i = 0; i < 6; i++) begin
            wr(8'h60, 8'h00);
            ev(5'h00, 1'h0, 1'h0, 6'h01 << i);
            ev(5'h00, 1'h1, 1'h0, 6'h00);
            rd(8'h80, oc[i]);
        end
        wr(8'h60, 8'h00);
        rd(8'h80, 8'h00);
        $display("test response done");
    endtask

    task automatic t_irq;
        wr(8'h0C, 8'h01);
        ev(5'h1F, 1'h0, 1'h0, 6'h00);
        rd(8'h84, 8'h00);
        wr(8'h10, 8'h1D);
        ev(5'h01, 1'h0, 1'h0, 6'h00);
        rd(8'h84, 8'h04);
        rd(8'hC4, 8'h02);
        ev(5'h02, 1'h0, 1'h0, 6'h00);
        rd(8'h84, 8'h0C);
        ev(5'h04, 1'h0, 1'h0, 6'h00);
        rd(8'h84, 8'h1C);
        ev(5'h10, 1'h0, 1'h0, 6'h00);
        rd(8'h84, 8'h1D);
        wr(8'h84, 8'h04);
        rd(8'h84, 8'h19);
        wr(8'h84, 8'h19);
        rd(8'hC4, 8'h01);
        ev(5'h08, 1'h0, 1'h0, 6'h00);
        rd(8'h84, 8'h01);
        wr(8'h84, 8'h01);
        wr(8'h10, 8'h02);
        ev(5'h08, 1'h0, 1'h0, 6'h00);
        rd(8'h84, 8'h00);
        wr(8'h0C, 8'h00);
        wr(8'h10, 8'h04);
        ev(5'h01, 1'h0, 1'h0, 6'h00);
        rd(8'hC4, 8'h03);
        wr(8'h0C, 8'h01);
        rd(8'hC4, 8'h02);
        wr(8'h10, 8'h00);
        rd(8'hC4, 8'h01);
        $display("test irq done");
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        t_regs();
        t_resp();
        t_irq();
        final_report();
    end

    // watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end
endmodule

bind sirs_top sirs_monitor u_sirs_monitor (.sys_clk(sys_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .command_value(command_value), .command_strobe(command_strobe),
    .irq_mode_reg_a(irq_mode_reg_a), .irq_mode_reg_b(irq_mode_reg_b),
    .led_one_current(led_one_current), .led_two_current(led_two_current),
    .led_three_current(led_three_current), .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe));
